// *** inc/rectifier_alarm_defines.svh ***
// constants of the rectifier alarm supervisor: offsets, fields, resets, limits
// assumes a 125 MHz system clock and temperatures in tenths of a degree
//
// Notes on behaviour
// - fuse alarm follows the fuse contact input being open, with no interlock
// - fuse lamp follows the alarm unless the lamp-disable option is set
// - equalize warning when equalizing is requested or running and block input open
// - equalize warning is held off while the block input is closed
// - equalize warning passes the alarm delay before it shows
// - equalize voltage raise is inhibited at once while block input is open
// - switched-off when mains switch is off or external block input open
// - mains and rectifier lamps are forced off while switched off
// - internal fault code has type digits low and extra digits high
// - type 01 flags an internal I2C error, extra digits hold its address
// - type 02 is never produced
// - type 03 when battery temperature is below the low limit
// - type 04 when battery temperature is above the high limit
// - type 05 when reference deviation leaves the tolerance band
// - type 06 when rectifier temperature is below the low limit
// - type 07 when rectifier temperature is above the high limit
// - network alarm after ten sends to a unit with no accepted answer
// - network alarm carries the address of the silent unit
// - single system: master address 0, slaves 1 to 7
// - second system: master 10, slaves 11 to 17, units digit is slave number
// - master raises slave alarm when any slave has an alarm relay active
// - earth measurement inhibited when address above one and parallel input open
`ifndef RECTIFIER_ALARM_DEFINES_SVH
`define RECTIFIER_ALARM_DEFINES_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_EQ_DELAY 8'h04
`define REG_STATUS 8'h08
`define REG_ERROR 8'h0C
`define REG_CLEAR 8'h10
`define REG_NETWORK 8'h14
// control fields
`define CTRL_LAMP_OFF_BIT 0
`define CTRL_EQ_REQ_BIT 1
`define CTRL_SYS2_BIT 2
`define CTRL_UNIT_LSB 4
`define CTRL_RESET 32'h0000_0000
`define EQ_DELAY_RESET 16'h0064
`define CLEAR_I2C_BIT 0
// error types as two decimal digits
`define ERR_NONE 8'h00
`define ERR_I2C 8'h01
`define ERR_BATT_LOW 8'h03
`define ERR_BATT_HIGH 8'h04
`define ERR_REF 8'h05
`define ERR_RECT_LOW 8'h06
`define ERR_RECT_HIGH 8'h07
// limits in tenths of a degree and tenths of a percent
`define BATT_TEMP_LOW 12'h00A
`define BATT_TEMP_HIGH 12'h1EA
`define RECT_TEMP_LOW 12'h00A
`define RECT_TEMP_HIGH 12'h5DC
`define REF_TOL 8'h05
// network
`define NET_ATTEMPTS 4'hA
`define SYS2_BASE 5'h0A
// timing
`define CLK_KHZ 125000
`define ALARM_TICK_MS 100
`endif

// *** inc/rectifier_alarm_pkg.sv ***
// types of the rectifier alarm supervisor
// assumes the defines header for every number
package rectifier_alarm_pkg;
  // contact inputs, 1 means the contact reads open
  typedef struct packed {
    logic fuseOpen;
    logic eqBlockOpen;
    logic mainsSwitchOff;
    logic extBlockOpen;
    logic parallelOpOpen;
  } contact_t;
  // alarm flags as read back in the status register
  typedef struct packed {
    logic slaveAlarm;
    logic earthInhibit;
    logic netAlarm;
    logic intFault;
    logic switchedOff;
    logic eqInhibit;
    logic eqWarning;
    logic fuseAlarm;
  } alarm_t;
endpackage

// *** src/rectifier_alarm_supervisor.sv ***
// alarm supervision for a charging rectifier with an AHB-Lite register slave
// assumes contact, measurement and network strobes synchronous to clk_sys
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rectifier_alarm_defines.svh"
module rectifier_alarm_supervisor #(
  parameter int TICK_CYCLES = `ALARM_TICK_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // contact inputs and plant state
  input wire rectifier_alarm_pkg::contact_t contacts,
  input wire logic eqRunning,
  input wire logic mainsOk,
  input wire logic rectOk,
  // measurements
  input wire logic [11:0] battTemp,
  input wire logic [11:0] rectTemp,
  input wire logic [7:0] refDeviation,
  input wire logic i2cError,
  input wire logic [7:0] i2cAddr,
  // network link events
  input wire logic netSend,
  input wire logic [4:0] netSendAddr,
  input wire logic netAnswer,
  input wire logic [7:1] slaveRelays,
  // alarm outputs
  output rectifier_alarm_pkg::alarm_t alarms,
  output logic fuseLamp,
  output logic mainsLamp,
  output logic rectLamp,
  output logic [15:0] errorCode,
  output logic errorCodeLong,
  output logic [4:0] netAlarmAddr,
  output logic [4:0] ownAddress
);

  // overview of behaviour and limits
  // every alarm flag is a registered level; all but the equalize warning are one edge behind their inputs, the internal fault being two behind i2cError
  // only the equalize warning passes the alarm delay, counted in ticks
  // a delay of zero still costs one edge before the warning shows
  // the equalize voltage inhibit never waits for the delay
  // mains and rectifier lamps are forced dark while switched off, whatever their sources say
  // internal faults are reported one at a time, lowest type first
  // an i2c fault hides all others until software clears it
  // the network count saturates, so the alarm stays until an answer comes
  // an answer in the same cycle as a send wins and clears the count
  // bus reads cost one wait state, writes none
  // hresp is always okay; unmapped reads return zero

  // network address from system and unit number
  function automatic logic [4:0] netAddr(input logic sys2, input logic [2:0] unit);
    logic [4:0] base;
    base = sys2 ? `SYS2_BASE : 5'h00;
    netAddr = base + {2'h0, unit};
  endfunction

  // signed temperature compare, true when a is below b
  function automatic logic tempBelow(input logic [11:0] a, input logic [11:0] b);
    tempBelow = $signed(a) < $signed(b);
  endfunction

  // switched off by the mains switch or the external block contact
  function automatic logic offNow(input rectifier_alarm_pkg::contact_t c);
    offNow = c.mainsSwitchOff | c.extBlockOpen;
  endfunction

  logic [31:0] ctrl;
  logic [15:0] eqDelay;
  logic wrPend;
  logic rdPend;
  logic [7:0] addrQ;
  logic i2cSticky;
  logic [7:0] i2cAddrQ;
  logic [3:0] sendCount;
  logic [23:0] tickCount;
  logic tick;
  logic [15:0] eqCount;
  logic eqCond;
  logic isMaster;
  logic [4:0] next_ownAddress;
  logic [7:0] next_errType;
  logic [7:0] next_errExtra;
  logic accept;
  logic clearI2c;
  // alarm flags, one flop each, gathered into the alarm output
  logic fuseAlarm;
  logic eqWarning;
  logic eqInhibit;
  logic switchedOff;
  logic intFault;
  logic netAlarm;
  logic slaveAlarm;
  logic earthInhibit;

  // address phase of a valid transfer
  assign accept = hsel & hready & htrans[1];

  // alarm output packed from its flops
  assign alarms = {slaveAlarm, earthInhibit, netAlarm, intFault, switchedOff, eqInhibit,
    eqWarning, fuseAlarm};

  // software clear of the i2c flag in the data phase of a write
  assign clearI2c = wrPend & (addrQ == `REG_CLEAR) & hwdata[`CLEAR_I2C_BIT];

  // own address: 0..7 in the first system, 10..17 in the second
  assign next_ownAddress = netAddr(ctrl[`CTRL_SYS2_BIT], ctrl[`CTRL_UNIT_LSB +: 3]);

  // master is unit number zero in either system
  assign isMaster = ctrl[`CTRL_UNIT_LSB +: 3] == 3'h0;

  // equalize requested or in progress while block contact is open
  assign eqCond = (ctrl[`CTRL_EQ_REQ_BIT] | eqRunning) & contacts.eqBlockOpen;

  // internal fault selection, lowest error type wins; type 02 is never chosen
  always_comb begin
    next_errType = `ERR_NONE;
    next_errExtra = 8'h00;
    if (i2cSticky) begin
      next_errType = `ERR_I2C;
      next_errExtra = i2cAddrQ;
    end else if (tempBelow(battTemp, `BATT_TEMP_LOW)) begin
      next_errType = `ERR_BATT_LOW;
    end else if (tempBelow(`BATT_TEMP_HIGH, battTemp)) begin
      next_errType = `ERR_BATT_HIGH;
    end else if (refDeviation > `REF_TOL) begin
      next_errType = `ERR_REF;
    end else if (tempBelow(rectTemp, `RECT_TEMP_LOW)) begin
      next_errType = `ERR_RECT_LOW;
    end else if (tempBelow(`RECT_TEMP_HIGH, rectTemp)) begin
      next_errType = `ERR_RECT_HIGH;
    end
  end

  // bus slave: writes have no wait state, reads add one
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      addrQ <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend <= accept & hwrite;
      rdPend <= accept & ~hwrite;
      if (accept) begin
        addrQ <= haddr;
      end
      if (accept & ~hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      hresp <= 1'b0;
    end
  end

  // read data loaded in the wait state; unmapped offsets read zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend) begin
      unique case (addrQ)
        `REG_CTRL: hrdata <= ctrl;
        `REG_EQ_DELAY: hrdata <= {16'h0000, eqDelay};
        `REG_STATUS: hrdata <= {24'h00_0000, alarms};
        `REG_ERROR: hrdata <= {15'h0000, errorCodeLong, errorCode};
        `REG_NETWORK: hrdata <= {18'h0_0000, sendCount, ownAddress, netAlarmAddr};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // control and delay registers written by software
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RESET;
      eqDelay <= `EQ_DELAY_RESET;
    end else if (wrPend) begin
      if (addrQ == `REG_CTRL) begin
        ctrl <= {25'h000_0000, hwdata[6:4], 1'b0, hwdata[2:0]};
      end
      if (addrQ == `REG_EQ_DELAY) begin
        eqDelay <= hwdata[15:0];
      end
    end
  end

  // fuse alarm and its lamp, lamp link removable by option
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fuseAlarm <= 1'b0;
      fuseLamp <= 1'b0;
    end else begin
      fuseAlarm <= contacts.fuseOpen;
      fuseLamp <= contacts.fuseOpen & ~ctrl[`CTRL_LAMP_OFF_BIT];
    end
  end

  // alarm delay time base, one tick each 100 ms
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tickCount <= 24'h00_0000;
      tick <= 1'b0;
    end else if (tickCount == 24'(TICK_CYCLES - 1)) begin
      tickCount <= 24'h00_0000;
      tick <= 1'b1;
    end else begin
      tickCount <= tickCount + 24'h00_0001;
      tick <= 1'b0;
    end
  end

  // equalize warning qualified by the alarm delay
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      eqCount <= 16'h0000;
      eqWarning <= 1'b0;
    end else if (!eqCond) begin
      eqCount <= 16'h0000;
      eqWarning <= 1'b0;
    end else begin
      if (eqCount >= eqDelay) begin
        eqWarning <= 1'b1;
      end else if (tick) begin
        eqCount <= eqCount + 16'h0001;
      end
    end
  end

  // equalize voltage raise inhibited with no delay
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      eqInhibit <= 1'b0;
    end else begin
      eqInhibit <= contacts.eqBlockOpen;
    end
  end

  // switched off state and the lamps it forces off
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      switchedOff <= 1'b0;
      mainsLamp <= 1'b0;
      rectLamp <= 1'b0;
    end else begin
      switchedOff <= offNow(contacts);
      if (offNow(contacts)) begin
        mainsLamp <= 1'b0;
        rectLamp <= 1'b0;
      end else begin
        mainsLamp <= mainsOk;
        rectLamp <= rectOk;
      end
    end
  end

  // i2c error kept until software clears it; a new error beats the clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      i2cSticky <= 1'b0;
      i2cAddrQ <= 8'h00;
    end else if (i2cError) begin
      i2cSticky <= 1'b1;
      i2cAddrQ <= i2cAddr;
    end else if (clearI2c) begin
      i2cSticky <= 1'b0;
    end
  end

  // internal fault flag and its error code
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      intFault <= 1'b0;
      errorCode <= 16'h0000;
      errorCodeLong <= 1'b0;
    end else begin
      intFault <= next_errType != `ERR_NONE;
      errorCode <= {next_errExtra, next_errType};
      errorCodeLong <= next_errType == `ERR_I2C;
    end
  end

  // network supervision: count sends without an accepted answer, saturating
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sendCount <= 4'h0;
    end else if (netAnswer) begin
      sendCount <= 4'h0;
    end else if (netSend && sendCount != `NET_ATTEMPTS) begin
      sendCount <= sendCount + 4'h1;
    end
  end

  // network alarm on the tenth unanswered send, with the silent address
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      netAlarm <= 1'b0;
      netAlarmAddr <= 5'h00;
    end else if (netAnswer) begin
      netAlarm <= 1'b0;
    end else if (netSend) begin
      netAlarmAddr <= netSendAddr;
      if (sendCount >= `NET_ATTEMPTS - 4'h1) begin
        netAlarm <= 1'b1;
      end
    end
  end

  // own address, slave alarm on the master, earth measurement inhibit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ownAddress <= 5'h00;
      slaveAlarm <= 1'b0;
      earthInhibit <= 1'b0;
    end else begin
      ownAddress <= next_ownAddress;
      slaveAlarm <= isMaster & (|slaveRelays);
      earthInhibit <= (next_ownAddress > 5'h01) & contacts.parallelOpOpen;
    end
  end

endmodule

// *** testbench/net_peer_model.sv ***
// network peer model answering the supervisor's sends
// assumes send pulses synchronous to clk_sys
`timescale 1ns/1ps
module net_peer_model (
  // clock
  input wire logic clk_sys,
  // link from the supervisor
  input wire logic netSend,
  input wire logic [4:0] netSendAddr,
  // behaviour controls
  input wire logic mute,
  input wire logic [3:0] lag,
  // answer back
  output logic netAnswer
);
  logic [3:0] waitCnt = 4'h0;
  logic valid;
  initial netAnswer = 1'b0;
  // only a unit at a legal address answers
  assign valid = netSendAddr <= 5'h07 || (netSendAddr >= 5'h0A && netSendAddr <= 5'h11);
  // answer pulse lag cycles after a send
  always @(posedge clk_sys) begin
    netAnswer <= waitCnt == 4'h1;
    if (waitCnt != 4'h0) waitCnt <= waitCnt - 4'h1;
    if (netSend && !mute && valid) waitCnt <= lag;
  end
endmodule

// *** testbench/rectifier_alarm_supervisor_monitor.sv ***
// port checker for the alarm supervisor
// assumes binding into the supervisor, one clock
`timescale 1ns/1ps
module rectifier_alarm_monitor #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // inputs
  input wire rectifier_alarm_pkg::contact_t contacts,
  input wire logic netSend,
  input wire logic [4:0] netSendAddr,
  input wire logic netAnswer,
  input wire logic [7:1] slaveRelays,
  // outputs
  input wire rectifier_alarm_pkg::alarm_t alarms,
  input wire logic mainsLamp,
  input wire logic rectLamp,
  input wire logic [15:0] errorCode,
  input wire logic errorCodeLong,
  input wire logic [4:0] netAlarmAddr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // alarm gone one edge after an answer
  sequence s_gone;
    ##1 !alarms.netAlarm;
  endsequence
  // port relations
  property p_fuse; 1'b1 |=> alarms.fuseAlarm == $past(contacts.fuseOpen); endproperty
  a_fuse: assert property (p_fuse) else $error("fuse alarm wrong");
  property p_inh; 1'b1 |=> alarms.eqInhibit == $past(contacts.eqBlockOpen); endproperty
  a_inh: assert property (p_inh) else $error("equalize inhibit wrong");
  property p_eqok; !contacts.eqBlockOpen |=> !alarms.eqWarning; endproperty
  a_eqok: assert property (p_eqok) else $error("equalize warning while permitted");
  property p_off;
    1'b1 |=> alarms.switchedOff == $past(contacts.mainsSwitchOff | contacts.extBlockOpen);
  endproperty
  a_off: assert property (p_off) else $error("switched off wrong");
  property p_dark; alarms.switchedOff |-> !mainsLamp && !rectLamp; endproperty
  a_dark: assert property (p_dark) else $error("lamp lit while off");
  property p_long; errorCodeLong |-> errorCode[7:0] == 8'h01; endproperty
  a_long: assert property (p_long) else $error("long code without bus type");
  property p_no2; errorCode[7:0] != 8'h02; endproperty
  a_no2: assert property (p_no2) else $error("unused type shown");
  property p_clr; netAnswer |-> s_gone; endproperty
  a_clr: assert property (p_clr) else $error("network alarm kept");
  property p_addr; netSend && !netAnswer |=> netAlarmAddr == $past(netSendAddr); endproperty
  a_addr: assert property (p_addr) else $error("network address wrong");
  property p_slave; alarms.slaveAlarm |-> $past(|slaveRelays); endproperty
  a_slave: assert property (p_slave) else $error("slave alarm without relay");
endmodule
bind rectifier_alarm_supervisor rectifier_alarm_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .contacts(contacts), .netSend(netSend),
  .netSendAddr(netSendAddr), .netAnswer(netAnswer), .slaveRelays(slaveRelays),
  .alarms(alarms), .mainsLamp(mainsLamp), .rectLamp(rectLamp), .errorCode(errorCode),
  .errorCodeLong(errorCodeLong), .netAlarmAddr(netAlarmAddr));

// *** testbench/rectifier_alarm_supervisor_bench.sv ***
// self-checking bench of the alarm supervisor
// assumes the defines header and a short alarm tick
`timescale 1ns/1ps
`include "rectifier_alarm_defines.svh"
module rectifier_alarm_supervisor_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  rectifier_alarm_pkg::contact_t contacts = '0;
  rectifier_alarm_pkg::alarm_t alarms;
  rectifier_alarm_pkg::alarm_t ea = '0;
  logic eqRunning = 1'b0;
  logic [11:0] battTemp = 12'h0FA;
  logic [11:0] rectTemp = 12'h190;
  logic [7:0] refDeviation = 8'h00;
  logic i2cError = 1'b0;
  logic [7:0] i2cAddr = 8'h00;
  logic netSend = 1'b0;
  logic [4:0] netSendAddr = 5'h00;
  logic netAnswer;
  logic [7:1] slaveRelays = 7'h00;
  logic mute = 1'b1;
  logic [3:0] lag = 4'h6;
  logic fuseLamp, mainsLamp, rectLamp, errorCodeLong;
  logic [15:0] errorCode;
  logic [4:0] netAlarmAddr, ownAddress;
  logic [7:0] a8;
  logic [31:0] seenq[$], expq[$];
  // battery, rectifier, reference, expected type
  logic [39:0] ec[9] = '{40'h009190_00_03, 40'h00A190_00_00, 40'h1EB190_00_04,
    40'h1EA190_00_00, 40'hFFB190_00_03, 40'h0FA190_06_05, 40'h0FA009_00_06,
    40'h0FA5DD_00_07, 40'h0095DD_00_03};
  int fail_count = 0;
  int cmp_count = 0;
  // clock
  always #4 clk_sys = ~clk_sys;
  rectifier_alarm_supervisor #(.TICK_CYCLES(4)) DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .contacts(contacts), .eqRunning(eqRunning),
    .mainsOk(1'b1), .rectOk(1'b1), .battTemp(battTemp), .rectTemp(rectTemp),
    .refDeviation(refDeviation), .i2cError(i2cError), .i2cAddr(i2cAddr), .netSend(netSend),
    .netSendAddr(netSendAddr), .netAnswer(netAnswer), .slaveRelays(slaveRelays),
    .alarms(alarms), .fuseLamp(fuseLamp), .mainsLamp(mainsLamp), .rectLamp(rectLamp),
    .errorCode(errorCode), .errorCodeLong(errorCodeLong), .netAlarmAddr(netAlarmAddr),
    .ownAddress(ownAddress));
  net_peer_model PEER (.clk_sys(clk_sys), .netSend(netSend), .netSendAddr(netSendAddr),
    .mute(mute), .lag(lag), .netAnswer(netAnswer));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // takes the oldest note whenever a result is posted
  always begin
    wait (seenq.size() > 0);
    chk(seenq.pop_front(), expq.pop_front());
  end
  task automatic note(input logic [31:0] s, input logic [31:0] e);
    expq.push_back(e);
    seenq.push_back(s);
  endtask
  task automatic al(input rectifier_alarm_pkg::alarm_t e);
    note(32'(alarms), 32'(e));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one single ahb-lite transfer
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (!hreadyout);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    note(q, e);
  endtask
  task automatic send(input logic [4:0] a);
    netSend <= 1'b1;
    netSendAddr <= a;
    tick(1);
    netSend <= 1'b0;
    tick(8);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(13));
    tick(8);
    sys_rst <= 1'b0;
    tick(1);
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_EQ_DELAY, {16'h0, `EQ_DELAY_RESET});
    rd(8'h20, 32'h0);
    wr(`REG_STATUS, 32'hFFFF_FFFF);
    rd(`REG_STATUS, 32'h0);
    $display("registers done");
    contacts.fuseOpen <= 1'b1;
    ea.fuseAlarm = 1'b1;
    tick(3);
    al(ea);
    note(32'(fuseLamp), 32'h1);
    wr(`REG_CTRL, 32'h1);
    tick(2);
    note(32'(fuseLamp), 32'h0);
    al(ea);
    contacts.fuseOpen <= 1'b0;
    ea.fuseAlarm = 1'b0;
    tick(3);
    al(ea);
    $display("fuse done");
    wr(`REG_EQ_DELAY, 32'h3);
    contacts.eqBlockOpen <= 1'b1;
    ea.eqInhibit = 1'b1;
    tick(2);
    al(ea);
    eqRunning <= 1'b1;
    tick(4);
    al(ea);
    tick(30);
    ea.eqWarning = 1'b1;
    al(ea);
    wr(`REG_CTRL, 32'h2);
    eqRunning <= 1'b0;
    tick(3);
    al(ea);
    contacts.eqBlockOpen <= 1'b0;
    ea = '0;
    tick(2);
    al(ea);
    wr(`REG_CTRL, 32'h0);
    $display("equalize done");
    for (int i = 0; i < 4; i++) begin
      contacts.mainsSwitchOff <= i[0];
      contacts.extBlockOpen <= i[1];
      ea.switchedOff = i != 0;
      tick(3);
      al(ea);
      note(32'({mainsLamp, rectLamp}), (i != 0) ? 32'h0 : 32'h3);
    end
    contacts.mainsSwitchOff <= 1'b0;
    contacts.extBlockOpen <= 1'b0;
    ea.switchedOff = 1'b0;
    for (int i = 0; i < 9; i++) begin
      battTemp <= ec[i][39:28];
      rectTemp <= ec[i][27:16];
      refDeviation <= ec[i][15:8];
      ea.intFault = ec[i][7:0] != 8'h00;
      tick(3);
      note(32'({errorCodeLong, errorCode}), {24'h0, ec[i][7:0]});
      al(ea);
    end
    battTemp <= 12'h0FA;
    rectTemp <= 12'h190;
    a8 = 8'($urandom);
    i2cAddr <= a8;
    i2cError <= 1'b1;
    tick(1);
    i2cError <= 1'b0;
    tick(3);
    ea.intFault = 1'b1;
    al(ea);
    rd(`REG_ERROR, {15'h0, 1'b1, a8, 8'h01});
    wr(`REG_CLEAR, 32'h1);
    ea.intFault = 1'b0;
    tick(2);
    note(32'({errorCodeLong, errorCode}), 32'h0);
    al(ea);
    $display("switch and fault done");
    for (int i = 1; i <= 10; i++) begin
      send(5'h03);
      ea.netAlarm = i == 10;
      al(ea);
    end
    note(32'(netAlarmAddr), 32'h3);
    mute <= 1'b0;
    send(5'h0B);
    ea.netAlarm = 1'b0;
    al(ea);
    note(32'(netAlarmAddr), 32'hB);
    mute <= 1'b1;
    for (int i = 0; i < 9; i++) send(5'h01);
    al(ea);
    $display("network done");
    contacts.parallelOpOpen <= 1'b1;
    slaveRelays <= 7'($urandom_range(127, 1));
    for (int s = 0; s < 2; s++)
      for (int u = 0; u < 8; u++) begin
        wr(`REG_CTRL, 32'(s * 4 + u * 16));
        tick(3);
        ea.earthInhibit = (s == 1) || (u > 1);
        ea.slaveAlarm = u == 0;
        al(ea);
        note(32'(ownAddress), 32'(s * 10 + u));
      end
    $display("address done");
    tick(4);
    summarize();
  end
endmodule
